// ### verilog/adc_spi_pkg.sv
// Purpose: shared constants and types of the converter serial frame interface
// Assumes: 50 MHz system clock, four channels, 16 meaningful bits per word
// Notes: control and status words sit on a small Avalon-MM register port
package adc_spi_pkg;
	// register byte offsets
	localparam logic [3:0] REG_CTRL_ADDR = 4'h0;
	localparam logic [3:0] REG_STAT_ADDR = 4'h4;
	// control field positions (match cfg_t packing)
	localparam int CTRL_WLEN_LSB = 0;
	localparam int CTRL_OD_BIT = 2;
	localparam int CTRL_CRC_EN_BIT = 3;
	localparam int CTRL_CRC_TYPE_BIT = 4;
	localparam int CTRL_TMO_BIT = 5;
	localparam int CFG_W = 6;
	// status field positions
	localparam int STAT_FLAGS_LSB = 0;
	localparam int STAT_CRC_ERR_BIT = 4;
	localparam int STAT_PIN_BIT = 5;
	// word length codes
	localparam logic [1:0] WLEN_16 = 2'h0;
	localparam logic [1:0] WLEN_24 = 2'h1;
	localparam logic [1:0] WLEN_32 = 2'h2;
	// frame layout
	localparam int CHANNELS = 4;
	localparam int DATA_BITS = 16;
	localparam logic [7:0] FRAME_WORDS = 8'h06;
	localparam logic [7:0] CRC_WORD_IDX = 8'h05;
	// checksum
	localparam logic [15:0] CRC_SEED = 16'hFFFF;
	localparam logic [15:0] POLY_CCITT = 16'h1021;
	localparam logic [15:0] POLY_ANSI = 16'h8005;
	// commands and answers
	localparam logic [15:0] CMD_NULL = 16'h0000;
	localparam logic [15:0] CMD_RESET = 16'h0011;
	localparam logic [15:0] ACK_RESET = 16'hFF54;
	localparam logic [15:0] ACK_RESET_SHORT = 16'h0011;
	localparam logic [2:0] WRITE_OPCODE = 3'h3;
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int READY_PULSE_NS = 200;
	localparam int READY_PULSE_CYC = (READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMEOUT_MCLK = 32768;

	typedef struct packed {
		logic timeout_en;
		logic crc_ansi;
		logic crc_in_en;
		logic ready_pin_open_drain_sel;
		logic [1:0] serial_word_length_sel;
	} cfg_t;

	localparam cfg_t CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, WLEN_24};

	typedef enum {RDY_IDLE, RDY_WAIT, RDY_PULSE} rdy_state_t;
endpackage

// ### verilog/adc_spi_frame_crc_interface.sv
// Purpose: serial frame peripheral of a four channel converter with checksums
// Assumes: spi pins are asynchronous and oversampled by clk_sys
// Notes: settings and status reachable over Avalon-MM
// Notes on behaviour
// - ready pin falls each time a new result set completes
// - ready pin rises only after all four channel words shifted out
// - partial readout keeps ready pin low
// - unread data at next completion gives a minimum high pulse before falling
// - completion during a data readout suppresses the high pulse
// - open-drain select bit: 0 drives high, 1 only pulls low
// - two-bit field selects 16, 24 or 32 bit words, 24 after reset
// - 16 data bits sit at word top, lower bits zero
// - frame opens with command in, response to previous command out
// - six word frame: response, four channel words, checksum
// - multi-register frames are longer or shorter than six words
// - reset command acts only when its frame is complete
// - both checksums are 16 bits and cover padding bits
// - input check off at reset; mismatch drops command except register write
// - checksum error sets status flag, next response is status; cleared when sent
// - output checksum word always ends the output frame; here it is fixed at word CRC_WORD_IDX, so it ends six word frames only
// - one bit selects polynomial for both directions, seed all ones
// - optional timeout resets interface if frame exceeds limit
// - status word carries four channel done flags, answer to no-op
// - channel results are 16-bit two's complement, low bits zero
// - output changes on rising, input sampled on falling serial clock
// - chip select high resets interface and floats data output
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
module adc_spi_frame_crc_interface import adc_spi_pkg::*; #(
	parameter int TIMEOUT_CYCLES = TIMEOUT_MCLK,
	parameter int READY_PULSE_CYCLES = READY_PULSE_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	output logic conversion_ready_n,
	output logic conversion_ready_oe,
	input wire logic conv_done,
	input wire logic [CHANNELS-1:0][DATA_BITS-1:0] ch_data,
	output logic [15:0] cmd_word,
	output logic cmd_strobe,
	output logic dev_reset_req
);
	localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
	localparam int PW = $clog2(READY_PULSE_CYCLES + 1);

	// pulse checker needs 8 to 47 high cycles
	if (TIMEOUT_CYCLES < 2 || READY_PULSE_CYCLES < 8 || READY_PULSE_CYCLES > 47) begin : g_chk
		$error("timeout or pulse count out of range");
	end

	cfg_t cfg_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic sclk_m, sclk_s, sclk_d, cs_m, cs_s, cs_d, din_m, din_s;
	logic rise, fall, cs_rise, active, ifr;
	logic [5:0] wl;
	logic [5:0] tx_pos_q, rx_pos_q;
	logic [7:0] tx_word_q, rx_word_q;
	logic [31:0] tx_sh_q;
	logic [15:0] rx_sh_q, tx_w16, crc_out_q, crc_in_q, crc_rx_q, cmd_q, poly, status_w;
	logic [15:0] resp_q, rx_w16;
	logic resp_status_q, crc_err_q, tx_bit, last_tx, last_rx, reading, rd_done;
	logic status_sent, crc_bad, dout_q, dout_oe_q, started_q;
	logic [TW-1:0] tmo_cnt_q;
	logic tmo_hit;
	logic [CHANNELS-1:0] flags_q, ch_clr;
	logic [CHANNELS-1:0][DATA_BITS-1:0] ch_q;
	rdy_state_t rdy_st_q;
	logic [PW-1:0] pcnt_q;
	logic ready_n_q, ready_oe_q, dev_reset_q, cmd_strobe_q;
	logic [15:0] cmd_word_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	function automatic logic [5:0] word_bits(input logic [1:0] sel);
		case (sel)
			WLEN_16: word_bits = 6'd16;
			WLEN_32: word_bits = 6'd32;
			default: word_bits = 6'd24;
		endcase
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b,
		input logic [15:0] p);
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? p : 16'h0000);
	endfunction

	// register port: one wait cycle, then the answer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			cfg_q <= CFG_RESET;
		end else begin
			if ((avs_read || avs_write) && wait_q) begin
				wait_q <= 1'b0;
				case (avs_address)
					REG_CTRL_ADDR: rdata_q <= {26'h0, cfg_q};
					REG_STAT_ADDR: rdata_q <= {26'h0, ready_n_q, crc_err_q, flags_q};
					default: rdata_q <= 32'h0000_0000;
				endcase
			end else begin
				wait_q <= 1'b1;
			end
			if (dev_reset_q) begin
				cfg_q <= CFG_RESET;
			end else if (avs_write && !wait_q && avs_address == REG_CTRL_ADDR) begin
				cfg_q <= cfg_t'(avs_writedata[CFG_W-1:0]);
			end
		end
	end

	// pin synchronisers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{sclk_m, sclk_s, sclk_d} <= 3'h0;
			{cs_m, cs_s, cs_d} <= 3'h7;
			{din_m, din_s} <= 2'h0;
		end else begin
			{sclk_m, sclk_s, sclk_d} <= {sclk, sclk_m, sclk_s};
			{cs_m, cs_s, cs_d} <= {cs_n, cs_m, cs_s};
			{din_m, din_s} <= {din, din_m};
		end
	end

	assign active = !cs_s;
	assign rise = active && sclk_s && !sclk_d;
	assign fall = active && !sclk_s && sclk_d;
	assign cs_rise = cs_s && !cs_d;
	assign tmo_hit = tmo_cnt_q == TW'(TIMEOUT_CYCLES - 1);
	assign ifr = cs_s || tmo_hit;
	assign wl = word_bits(cfg_q.serial_word_length_sel);
	assign last_tx = tx_pos_q == wl - 6'd1;
	assign last_rx = rx_pos_q == wl - 6'd1;
	assign poly = cfg_q.crc_ansi ? POLY_ANSI : POLY_CCITT;
	assign status_w = {11'h000, crc_err_q, flags_q};
	assign reading = active && tx_word_q >= 8'd1 && tx_word_q <= 8'd4;
	assign rd_done = rise && last_tx && tx_word_q == 8'd4;
	assign status_sent = rise && tx_pos_q == 6'd0 && tx_word_q == 8'd0 && resp_status_q;
	assign rx_w16 = {rx_sh_q[14:0], din_s};
	assign crc_bad = cfg_q.crc_in_en && (rx_word_q < 8'd2 || crc_rx_q != crc_in_q);

	// outgoing word selection
	always_comb begin
		case (tx_word_q)
			8'd0: tx_w16 = resp_status_q ? status_w : resp_q;
			8'd1: tx_w16 = ch_q[0];
			8'd2: tx_w16 = ch_q[1];
			8'd3: tx_w16 = ch_q[2];
			8'd4: tx_w16 = ch_q[3];
			CRC_WORD_IDX: tx_w16 = crc_out_q;
			default: tx_w16 = 16'h0000;
		endcase
	end

	assign tx_bit = (tx_pos_q == 6'd0) ? tx_w16[15] : tx_sh_q[31];

	// frame timeout
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			started_q <= 1'b0;
			tmo_cnt_q <= '0;
		end else if (ifr) begin
			started_q <= 1'b0;
			tmo_cnt_q <= '0;
		end else begin
			if (rise || fall) begin
				started_q <= 1'b1;
			end
			if (started_q && cfg_q.timeout_en) begin
				tmo_cnt_q <= tmo_cnt_q + TW'(1);
			end else begin
				tmo_cnt_q <= '0;
			end
		end
	end

	// transmit on rising serial clock
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_pos_q <= 6'd0;
			tx_word_q <= 8'd0;
			tx_sh_q <= 32'h0000_0000;
			crc_out_q <= CRC_SEED;
			dout_q <= 1'b0;
		end else if (ifr) begin
			tx_pos_q <= 6'd0;
			tx_word_q <= 8'd0;
			crc_out_q <= CRC_SEED;
		end else if (rise) begin
			dout_q <= tx_bit;
			if (tx_pos_q == 6'd0) begin
				tx_sh_q <= {tx_w16[14:0], 17'h0_0000};
			end else begin
				tx_sh_q <= {tx_sh_q[30:0], 1'b0};
			end
			if (tx_word_q < CRC_WORD_IDX) begin
				crc_out_q <= crc_step(crc_out_q, tx_bit, poly);
			end
			if (last_tx) begin
				tx_pos_q <= 6'd0;
				if (tx_word_q != 8'hFF) begin
					tx_word_q <= tx_word_q + 8'd1;
				end
			end else begin
				tx_pos_q <= tx_pos_q + 6'd1;
			end
		end
	end

	// receive on falling serial clock
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_pos_q <= 6'd0;
			rx_word_q <= 8'd0;
			rx_sh_q <= 16'h0000;
			crc_in_q <= CRC_SEED;
			crc_rx_q <= 16'h0000;
			cmd_q <= CMD_NULL;
		end else if (ifr) begin
			rx_pos_q <= 6'd0;
			rx_word_q <= 8'd0;
			crc_in_q <= CRC_SEED;
		end else if (fall) begin
			rx_sh_q <= rx_w16;
			if (rx_word_q == 8'd0) begin
				crc_in_q <= crc_step(crc_in_q, din_s, poly);
			end
			if (rx_pos_q == 6'd15 && rx_word_q == 8'd0) begin
				cmd_q <= rx_w16;
			end
			if (rx_pos_q == 6'd15 && rx_word_q == 8'd1) begin
				crc_rx_q <= rx_w16;
			end
			if (last_rx) begin
				rx_pos_q <= 6'd0;
				if (rx_word_q != 8'hFF) begin
					rx_word_q <= rx_word_q + 8'd1;
				end
			end else begin
				rx_pos_q <= rx_pos_q + 6'd1;
			end
		end
	end

	// command execution at frame end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			resp_q <= CMD_NULL;
			resp_status_q <= 1'b1;
			dev_reset_q <= 1'b0;
			cmd_strobe_q <= 1'b0;
			cmd_word_q <= CMD_NULL;
		end else begin
			dev_reset_q <= 1'b0;
			cmd_strobe_q <= 1'b0;
			if (cs_rise) begin
				cmd_word_q <= cmd_q;
				resp_q <= cmd_q;
				resp_status_q <= 1'b0;
				if (rx_word_q == 8'd0) begin
					resp_status_q <= 1'b1;
				end else if (crc_bad) begin
					resp_status_q <= 1'b1;
					cmd_strobe_q <= cmd_q[15:13] == WRITE_OPCODE;
				end else if (cmd_q == CMD_RESET) begin
					if (rx_word_q >= FRAME_WORDS) begin
						resp_q <= ACK_RESET;
						dev_reset_q <= 1'b1;
					end else begin
						resp_q <= ACK_RESET_SHORT;
					end
				end else begin
					cmd_strobe_q <= 1'b1;
					resp_status_q <= cmd_q == CMD_NULL;
				end
			end
		end
	end

	// checksum error flag, set wins over clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			crc_err_q <= 1'b0;
		end else if (cs_rise && rx_word_q != 8'd0 && crc_bad) begin
			crc_err_q <= 1'b1;
		end else if (status_sent) begin
			crc_err_q <= 1'b0;
		end
	end

	// per channel sample hold and done flags
	for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
		assign ch_clr[i] = rise && last_tx && tx_word_q == 8'(i + 1);
		always_ff @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				flags_q[i] <= 1'b0;
				ch_q[i] <= '0;
			end else if (conv_done) begin
				flags_q[i] <= 1'b1;
				ch_q[i] <= ch_data[i];
			end else if (ch_clr[i]) begin
				flags_q[i] <= 1'b0;
			end
		end
	end

	// ready pin state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdy_st_q <= RDY_IDLE;
			pcnt_q <= '0;
		end else if (conv_done) begin
			case (rdy_st_q)
				RDY_IDLE: rdy_st_q <= RDY_WAIT;
				RDY_WAIT: begin
					if (!reading) begin
						rdy_st_q <= RDY_PULSE;
						pcnt_q <= PW'(READY_PULSE_CYCLES - 1);
					end
				end
				default: begin
					rdy_st_q <= RDY_PULSE;
					pcnt_q <= PW'(READY_PULSE_CYCLES - 1);
				end
			endcase
		end else begin
			case (rdy_st_q)
				RDY_WAIT: begin
					if (rd_done) begin
						rdy_st_q <= RDY_IDLE;
					end
				end
				RDY_PULSE: begin
					if (pcnt_q == '0) begin
						rdy_st_q <= RDY_WAIT;
					end else begin
						pcnt_q <= pcnt_q - PW'(1);
					end
				end
				default: rdy_st_q <= RDY_IDLE;
			endcase
		end
	end

	// pin drivers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ready_n_q <= 1'b1;
			ready_oe_q <= 1'b1;
			dout_oe_q <= 1'b0;
		end else begin
			ready_n_q <= rdy_st_q != RDY_WAIT;
			ready_oe_q <= !cfg_q.ready_pin_open_drain_sel || rdy_st_q == RDY_WAIT;
			dout_oe_q <= active;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign dout = dout_q;
	assign dout_oe = dout_oe_q;
	assign conversion_ready_n = ready_n_q;
	assign conversion_ready_oe = ready_oe_q;
	assign cmd_word = cmd_word_q;
	assign cmd_strobe = cmd_strobe_q;
	assign dev_reset_req = dev_reset_q;

	sequence s_pulse_start;
		conv_done && rdy_st_q == RDY_WAIT && !reading;
	endsequence
	sequence s_pulse_body;
		ready_n_q [*8] ##[1:40] !ready_n_q;
	endsequence

	property p_fall;
		conv_done && rdy_st_q == RDY_IDLE |-> ##2 !ready_n_q;
	endproperty
	a_fall: assert property (p_fall) else $error("ready did not fall");
	property p_release;
		rd_done && !conv_done && rdy_st_q == RDY_WAIT |-> ##2 ready_n_q;
	endproperty
	a_release: assert property (p_release) else $error("ready not released");
	property p_partial;
		cs_rise && rdy_st_q == RDY_WAIT && !conv_done |=> rdy_st_q == RDY_WAIT ##1 !ready_n_q;
	endproperty
	a_partial: assert property (p_partial) else $error("ready released early");
	property p_pulse;
		s_pulse_start |-> ##2 s_pulse_body;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready pulse wrong");
	property p_suppress;
		conv_done && rdy_st_q == RDY_WAIT && reading |-> ##2 !ready_n_q;
	endproperty
	a_suppress: assert property (p_suppress) else $error("pulse not blocked");
	property p_open_drain;
		$past(cfg_q.ready_pin_open_drain_sel) && ready_n_q |-> !ready_oe_q;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("ready driven high");
	property p_pad;
		rise && tx_pos_q >= 6'd16 |=> !dout_q;
	endproperty
	a_pad: assert property (p_pad) else $error("padding not zero");
	property p_short_reset;
		cs_rise && rx_word_q != 8'd0 && rx_word_q < FRAME_WORDS |=> !dev_reset_req;
	endproperty
	a_short_reset: assert property (p_short_reset) else $error("reset on short frame");
	property p_crc_err;
		cs_rise && rx_word_q != 8'd0 && crc_bad |=> crc_err_q && resp_status_q;
	endproperty
	a_crc_err: assert property (p_crc_err) else $error("crc error not flagged");
	property p_crc_out;
		rise && tx_pos_q == 6'd0 && tx_word_q == CRC_WORD_IDX |=> dout_q == crc_out_q[15];
	endproperty
	a_crc_out: assert property (p_crc_out) else $error("crc word wrong");
	property p_timeout;
		tmo_hit |=> rx_word_q == 8'd0 && tx_word_q == 8'd0 && !started_q;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not reset");
	property p_hiz;
		cs_s |=> !dout_oe;
	endproperty
	a_hiz: assert property (p_hiz) else $error("dout driven while deselected");
endmodule

// ### verif/spi_host_model.sv
// Purpose: host serial controller model driving frames into the converter interface
// Assumes: clk_sys sampled timing, four clk_sys per serial clock half period (80 ns)
// Notes: received words land right aligned in rx, one entry per word
`timescale 1ns/1ns
module spi_host_model #(
	parameter int STALL = 4200
) (
	input wire logic clk_sys,
	input wire logic dout,
	input wire logic dout_oe,
	output logic sclk,
	output logic cs_n,
	output logic din
);
	logic [31:0] rx [0:7];
	logic last_q;
	logic line;

	// a released data line shows the inverse of its last driven level
	assign line = dout_oe ? dout : ~last_q;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		last_q = 1'b0;
	end
	always @(posedge clk_sys) begin
		if (dout_oe)
			last_q <= dout;
	end

	// launch on serial clock rise, capture at the fall, clock idles low
	task automatic bit_io(input logic v, output logic r);
		sclk <= 1'b1;
		din <= v;
		repeat (4) @(posedge clk_sys);
		r = line;
		sclk <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	// pre junk bits followed by a stall exercise the frame timeout
	task automatic frame(input int nw, input int wl, input logic [15:0] w0, input logic [15:0] w1,
		input int pre);
		logic [31:0] tx;
		logic r;
		int i;
		int b;
		@(posedge clk_sys);
		cs_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		for (i = 0; i < pre; i++) begin
			bit_io(1'b1, r);
		end
		if (pre > 0)
			repeat (STALL) @(posedge clk_sys);
		for (i = 0; i < nw; i++) begin
			// command first, then its checksum or zeros, then zero words
			tx = (i == 0) ? {w0, 16'h0} : (i == 1) ? {w1, 16'h0} : 32'h0;
			rx[i] = 32'h0;
			for (b = 0; b < wl; b++) begin
				bit_io(tx[31-b], r);
				rx[i] = {rx[i][30:0], r};
			end
		end
		cs_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask
endmodule

// ### verif/tb.sv
// Purpose: self-checking bench of the converter serial frame interface
// Assumes: host model on the link, Avalon-MM register access, 50 MHz clock
// Notes: reduced timeout parameter keeps the stall short
`timescale 1ns/1ns
module tb;
	import adc_spi_pkg::*;
	localparam int PULSE = 10;
	localparam int TMO = 4096;
	logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, sclk, cs_n, din, dout, dout_oe;
	logic conversion_ready_n, conversion_ready_oe, conv_done, cmd_strobe, dev_reset_req, ansi;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdata, seed;
	logic [CHANNELS-1:0][DATA_BITS-1:0] ch_data;
	logic [15:0] cmd_word, last_cmd, crc_a, crc_b;
	logic [15:0] chv [0:3];
	int err_total, checks_done, wl, n_strobe, n_rst, i, hi;

	adc_spi_frame_crc_interface #(.TIMEOUT_CYCLES(TMO), .READY_PULSE_CYCLES(PULSE))
		adc_spi_frame_crc_interface_inst (.clk_sys(clk_sys), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.dout_oe(dout_oe), .conversion_ready_n(conversion_ready_n),
		.conversion_ready_oe(conversion_ready_oe), .conv_done(conv_done), .ch_data(ch_data),
		.cmd_word(cmd_word), .cmd_strobe(cmd_strobe), .dev_reset_req(dev_reset_req));
	spi_host_model #(.STALL(TMO + 100)) spi_host_model_inst (.clk_sys(clk_sys), .dout(dout),
		.dout_oe(dout_oe), .sclk(sclk), .cs_n(cs_n), .din(din));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (cmd_strobe === 1'b1) begin
			n_strobe <= n_strobe + 1;
			last_cmd <= cmd_word;
		end
		if (dev_reset_req === 1'b1)
			n_rst <= n_rst + 1;
	end
	initial begin
		repeat (80000) @(posedge clk_sys);
		err_total++;
		close_out();
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// checksum fold, msb first over n bits of w
	function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [31:0] w, input int n);
		logic [15:0] p;
		int k;
		p = ansi ? POLY_ANSI : POLY_CCITT;
		for (k = n - 1; k >= 0; k--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ w[k]) ? p : 16'h0);
		return c;
	endfunction
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0)
				break;
		end
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			err_total++;
			close_out();
		end
		@(posedge clk_sys);
	endtask
	task automatic wait_rdy(input logic v);
		int n;
		for (n = 0; n < 3000; n++) begin
			@(posedge clk_sys);
			if (conversion_ready_n === v)
				break;
		end
		if (conversion_ready_n !== v) begin
			err_total++;
			close_out();
		end
	endtask
	task automatic conv(input logic fresh);
		int k;
		if (fresh)
			ch_data <= {xs(), xs()};
		conv_done <= 1'b1;
		@(posedge clk_sys);
		conv_done <= 1'b0;
		for (k = 0; k < 4; k++)
			chv[k] = ch_data[k];
	endtask
	// fm masks response bits whose sampling moment is left open (channel flags)
	task automatic run_frame(input int nw, input logic [15:0] cmd, input logic [15:0] w1,
		input int pre, input logic [15:0] resp, input logic [15:0] fm);
		logic [15:0] c, w;
		logic [31:0] e;
		int k;
		spi_host_model_inst.frame(nw, wl, cmd, w1, pre);
		c = CRC_SEED;
		for (k = 0; k < nw && k < 6; k++) begin
			if (k == 0)
				w = (resp & fm) | (spi_host_model_inst.rx[0][wl-1 -: 16] & ~fm);
			else if (k < 5)
				w = chv[k-1];
			else
				w = c;
			e = {w, 16'h0} >> (32 - wl);
			chk(spi_host_model_inst.rx[k], e);
			c = crc_word(c, e, wl);
		end
		chk(dout_oe, 1'b0);
	endtask

	initial begin
		rst = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		conv_done = 1'b0;
		ch_data = '0;
		seed = 32'h766F;
		err_total = 0;
		checks_done = 0;
		n_strobe = 0;
		n_rst = 0;
		ansi = 1'b0;
		wl = 24;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(conversion_ready_n, 1'b1);
		av(1'b0, REG_CTRL_ADDR, 32'h0);
		chk(rdata, 32'h1);
		av(1'b0, 4'h8, 32'h0);
		chk(rdata, 32'h0);
		for (i = 0; i < 4; i++) begin
			wl = (i == 0) ? 16 : (i == 2) ? 32 : 24;
			ansi = i[0];
			av(1'b1, REG_CTRL_ADDR, {26'h0, 1'b0, ansi, 1'b0, i == 1, i[1:0]});
			conv(1'b1);
			wait_rdy(1'b0);
			if (i == 1)
				chk(conversion_ready_oe, 1'b1);
			run_frame(6, CMD_NULL, 16'h0, 0, 16'h0, 16'hFFF0);
			repeat (4) @(posedge clk_sys);
			chk(conversion_ready_n, 1'b1);
			if (i == 1)
				chk(conversion_ready_oe, 1'b0);
		end
		conv(1'b1);
		wait_rdy(1'b0);
		run_frame(2, CMD_NULL, 16'h0, 0, 16'h0, 16'hFFF0);
		repeat (4) @(posedge clk_sys);
		chk(conversion_ready_n, 1'b0);
		run_frame(1, CMD_NULL, 16'h0, 0, 16'h000E, 16'hFFFF);
		av(1'b0, REG_STAT_ADDR, 32'h0);
		chk(rdata, 32'h0000_000E);
		conv(1'b1);
		hi = 0;
		repeat (60) begin
			@(posedge clk_sys);
			if (conversion_ready_n === 1'b1)
				hi++;
		end
		chk(hi, PULSE);
		chk(conversion_ready_n, 1'b0);
		fork
			run_frame(6, CMD_NULL, 16'h0, 0, 16'h0, 16'hFFF0);
			begin
				repeat (600) @(posedge clk_sys);
				conv(1'b0);
				hi = 0;
				repeat (40) begin
					@(posedge clk_sys);
					if (conversion_ready_n !== 1'b0)
						hi++;
				end
				chk(hi, 0);
			end
		join
		ansi = 1'b0;
		av(1'b1, REG_CTRL_ADDR, 32'h09);
		crc_a = crc_word(CRC_SEED, {16'h0022, 8'h0}, 24);
		crc_b = crc_word(CRC_SEED, 32'h0, 24);
		hi = n_strobe;
		run_frame(6, 16'h0022, ~crc_a, 0, 16'h0, 16'hFFF0);
		repeat (8) @(posedge clk_sys);
		chk(n_strobe, hi);
		run_frame(6, CMD_NULL, crc_b, 0, 16'h0010, 16'hFFF0);
		run_frame(6, 16'h0022, crc_a, 0, 16'h0, 16'hFFF0);
		repeat (8) @(posedge clk_sys);
		chk(n_strobe, hi + 2);
		chk(last_cmd, 16'h0022);
		av(1'b1, REG_CTRL_ADDR, 32'h21);
		run_frame(6, 16'h0033, 16'h0, 5, 16'h0022, 16'hFFFF);
		repeat (8) @(posedge clk_sys);
		chk(last_cmd, 16'h0033);
		hi = n_rst;
		run_frame(1, CMD_RESET, 16'h0, 0, 16'h0033, 16'hFFFF);
		repeat (8) @(posedge clk_sys);
		chk(n_rst, hi);
		run_frame(6, CMD_RESET, 16'h0, 0, ACK_RESET_SHORT, 16'hFFFF);
		repeat (8) @(posedge clk_sys);
		chk(n_rst, hi + 1);
		run_frame(1, CMD_NULL, 16'h0, 0, ACK_RESET, 16'hFFFF);
		av(1'b0, REG_CTRL_ADDR, 32'h0);
		chk(rdata, 32'h1);
		close_out();
	end
endmodule
